/* rtl/ext_bus_if.sv */
// external memory bus interface: multiplexed address/data, strobes, selects, hold
// assumes bus clock, hold, ready, width and boot pins arrive asynchronously
//
// The register offsets and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
// How it works
// R1: area selects go low while an external access falls in their bank range.
// R2: ready sample strobe marks external data terms; ready low stretches the data term for as long as it stays low.
// R3: ready stretch adds on top of programmed wait and lasts while ready stays low.
// R4: 16-bit: upper port drives A15-A8, then carries odd data in strobe term.
// R5: 8-bit: upper port is address output only, never data.
// R6: 16-bit: lower port drives A7-A0, then carries even data in strobe term.
// R7: 8-bit: lower port drives A7-A0, then carries the selected data byte.
// R8: internal reads ignore external port data while read strobe is low.
// R9: outside single-chip, port3 low bits become strobes, latch strobe, hold ack.
// R10: 16-bit writes: low strobe even, high strobe odd, both for words.
// R11: 8-bit writes: only the low write strobe asserts, high stays high.
// R12: suppress bit set hides read and write strobes on internal accesses.
// R13: outside latch passes address while latch strobe high, holds when low.
// R14: hold request taken on internal clock fall while idle, ack goes low.
// R15: bus pins float one internal clock after ack falls.
// R16: bus pins driven again one internal clock after ack rises.
// R17: ready low freezes the internal clock in its low phase.
// R18: port4 bit2 gives bus clock when enabled; it keeps running during ready stop.
// R19: boot pin high starts microprocessor mode; software writes mode bits otherwise.
// R20: microprocessor mode outputs bus clock while suppress is clear, ignoring the enable bit.
// R21: microprocessor mode with suppress set outputs port latch instead of clock.
// R22: read strobe pin: enable signal or low in single-chip, standby levels otherwise.
// R23: expansion: port0 gives A16, A17, ready sample strobe and area selects.
// R24: external waits give 1.5x or 2x access time; internal takes no programmed wait, only the ready stretch.
// R25: strobes and phases come from the internal clock, address then data.
module ext_bus_if
  import ext_bus_pkg::*;
(
  input wire logic sys_clk_i, // system clock
  input wire logic resetn_i, // async reset, active low
  input wire logic bus_clk_i, // bus clock from pin
  input wire logic boot_mode_pin_i, // boot strap pin
  input wire logic byte_width_i, // high selects 8-bit bus
  input wire logic hold_req_n_i, // bus release request
  input wire logic ready_n_i, // ready input
  input wire logic wait_instruction_i, // standby after wait instruction
  input wire logic stop_instruction_i, // standby after stop instruction
  input wire logic [1:0] reg_addr_i, // register index
  input wire logic [7:0] reg_wdata_i, // register write data
  input wire logic reg_we_i, // register write strobe
  input wire logic reg_re_i, // register read strobe
  output logic [7:0] reg_rdata_o, // register read data
  input wire logic req_i, // access request pulse
  input wire logic [23:0] req_addr_i, // access address
  input wire logic req_we_i, // write access
  input wire logic [1:0] req_be_i, // byte enables, bit1 odd byte
  input wire logic req_internal_i, // address hits internal memory
  input wire logic [15:0] req_wdata_i, // write data
  input wire logic [15:0] int_rdata_i, // internal memory read data
  output logic busy_o, // access or hold in progress
  output logic done_o, // access finished pulse
  output logic [15:0] rdata_o, // read data
  input wire logic [7:0] p1_i, // upper port input
  output logic [7:0] p1_o, // upper port output
  output logic p1_oe_n_o, // upper port drive, low drives
  input wire logic [7:0] p2_i, // lower port input
  output logic [7:0] p2_o, // lower port output
  output logic p2_oe_n_o, // lower port drive, low drives
  output logic [1:0] addr_hi_o, // A16, A17
  output logic [4:0] area_select_n_o, // area selects
  output logic ready_sample_strobe_n_o, // ready sampling strobe
  output logic p0_oe_n_o, // port0 drive, low drives
  output logic read_strobe_n_o, // read strobe or enable pin
  output logic write_strobe_low_byte_n_o, // low write strobe
  output logic write_strobe_high_byte_n_o, // high write strobe
  output logic strobe_oe_n_o, // strobe pins drive, low drives
  output logic ale_o, // address latch strobe
  output logic bus_release_ack_n_o, // hold acknowledge
  output logic port3_ctrl_o, // port3 low bits carry bus control
  output logic internal_clk_run_o, // internal clock running
  output logic bus_clk_o // port4 bit2 output
);

  function automatic logic [4:0] area_decode(input logic [23:0] a, input logic intl);
    logic [4:0] cs;
    cs = CS_NONE;
    if (!intl) begin
      if (a[23:16] == 8'h00 && !a[15]) cs[0] = 1'b0;
      else if (a[23:16] <= BANK_CS1_LAST) cs[1] = 1'b0;
      else if (a[23:16] <= BANK_CS2_LAST) cs[2] = 1'b0;
      else if (a[23:16] <= BANK_CS3_LAST) cs[3] = 1'b0;
      else if (a[23:16] <= BANK_CS4_LAST) cs[4] = 1'b0;
    end
    return cs;
  endfunction

  logic [4:0] sync1_q, sync2_q;
  logic bclk_d_q;
  logic bclk_s, boot_s, byte_s, hold_n_s, ready_n_s;
  logic edge_w, fall_w;
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sync1_q <= 5'h1e;
      sync2_q <= 5'h1e;
      bclk_d_q <= 1'b0;
    end else begin
      sync1_q <= {ready_n_i, hold_req_n_i, byte_width_i, boot_mode_pin_i, bus_clk_i};
      sync2_q <= sync1_q;
      bclk_d_q <= sync2_q[0];
    end
  end
  assign bclk_s = sync2_q[0];
  assign boot_s = sync2_q[1];
  assign byte_s = sync2_q[2];
  assign hold_n_s = sync2_q[3];
  assign ready_n_s = sync2_q[4];
  assign edge_w = bclk_s ^ bclk_d_q;
  assign fall_w = bclk_d_q & ~bclk_s;

  // registers; the strap waits until both sync stages hold the pin, not their reset value
  logic [7:0] mode0_q, mode1_q;
  logic boot_done_q;
  logic [1:0] boot_pipe_q;
  logic [1:0] mode_w;
  logic expand_w, suppress_w;
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mode0_q <= MODE0_RST;
      mode1_q <= MODE1_RST;
      boot_done_q <= 1'b0;
      boot_pipe_q <= 2'h0;
    end else begin
      boot_pipe_q <= {boot_pipe_q[0], 1'b1};
      boot_done_q <= boot_pipe_q[1];
      if (!boot_done_q && boot_pipe_q[1] && boot_s) mode0_q[M0_MODE_LSB+:2] <= MODE_MICRO; // R19
      else if (reg_we_i && reg_addr_i == REG_MODE0) mode0_q <= reg_wdata_i; // R19
      if (reg_we_i && reg_addr_i == REG_MODE1) mode1_q <= reg_wdata_i;
    end
  end
  assign mode_w = mode0_q[M0_MODE_LSB+:2];
  assign expand_w = (mode_w != MODE_SINGLE);
  assign suppress_w = mode1_q[M1_SUPPRESS];

  bus_state_e state_q;
  logic [2:0] cnt_q;
  logic [23:0] addr_q;
  logic [15:0] wdata_q;
  logic [1:0] be_q;
  logic we_q, int_q, float_q;
  logic [2:0] data_len_w;
  logic stall_w;

  always_comb begin
    data_len_w = DATA_HALVES_NOWAIT;
    if (!int_q && !mode0_q[M0_WAIT]) begin
      data_len_w = mode1_q[M1_WAIT_SEL] ? DATA_HALVES_WAIT15 : DATA_HALVES_WAIT2; // R24
    end
  end
  // ready stops the internal clock low; extra time stacks on the wait setting
  assign stall_w = !ready_n_s && state_q == ST_DATA; // R17 R3

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q <= ST_IDLE;
      cnt_q <= 3'h0;
      float_q <= 1'b0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          cnt_q <= 3'h0;
          if (expand_w && !hold_n_s && fall_w) begin
            state_q <= ST_HOLD; // R14
          end else if (req_i) begin
            state_q <= ST_ADDR; // R25
          end
        end
        ST_ADDR: begin
          if (edge_w) begin
            if (cnt_q + 3'h1 == ADDR_HALVES) begin
              cnt_q <= 3'h0;
              state_q <= ST_DATA; // R25
            end else cnt_q <= cnt_q + 3'h1;
          end
        end
        ST_DATA: begin
          if (edge_w && !stall_w) begin // R17 R2
            if (cnt_q + 3'h1 == data_len_w) begin
              cnt_q <= 3'h0;
              state_q <= ST_IDLE;
            end else cnt_q <= cnt_q + 3'h1;
          end
        end
        ST_HOLD: begin
          if (edge_w && cnt_q != HOLD_FLOAT_HALVES) cnt_q <= cnt_q + 3'h1;
          if (cnt_q == HOLD_FLOAT_HALVES) float_q <= 1'b1; // R15
          if (hold_n_s && cnt_q == HOLD_FLOAT_HALVES) begin
            cnt_q <= 3'h0;
            state_q <= ST_UNHOLD;
          end
        end
        ST_UNHOLD: begin
          if (edge_w) cnt_q <= cnt_q + 3'h1;
          if (cnt_q == HOLD_FLOAT_HALVES) begin
            float_q <= 1'b0; // R16
            cnt_q <= 3'h0;
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // request capture
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      addr_q <= 24'h000000;
      wdata_q <= 16'h0000;
      be_q <= 2'h0;
      we_q <= 1'b0;
      int_q <= 1'b0;
    end else if (state_q == ST_IDLE && req_i && !(expand_w && !hold_n_s && fall_w)) begin
      addr_q <= req_addr_i;
      wdata_q <= req_wdata_i;
      be_q <= req_be_i;
      we_q <= req_we_i;
      int_q <= req_internal_i || !expand_w;
    end
  end

  // completion and read data
  logic last_w;
  assign last_w = state_q == ST_DATA && edge_w && !stall_w && cnt_q + 3'h1 == data_len_w;
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      done_o <= 1'b0;
      rdata_o <= 16'h0000;
      busy_o <= 1'b0;
    end else begin
      done_o <= last_w;
      busy_o <= state_q != ST_IDLE || req_i;
      if (last_w && !we_q) begin
        if (int_q) rdata_o <= int_rdata_i; // R8
        else if (!byte_s) rdata_o <= {p1_i, p2_i}; // R4 R6
        else rdata_o <= {p2_i, p2_i}; // R7
      end
    end
  end

  // pin values, each registered before leaving the block
  logic addr_ph_w, data_ph_w, ext_w, standby_w;
  logic rd_n_d, wl_n_d, wh_n_d;
  assign addr_ph_w = state_q == ST_ADDR;
  assign data_ph_w = state_q == ST_DATA;
  assign ext_w = !int_q && expand_w;
  assign standby_w = wait_instruction_i || stop_instruction_i;

  always_comb begin
    rd_n_d = 1'b1;
    wl_n_d = 1'b1;
    wh_n_d = 1'b1;
    if (!expand_w) begin
      rd_n_d = suppress_w ? 1'b0 : !data_ph_w; // R22
    end else if (standby_w) begin
      rd_n_d = !(suppress_w && mode1_q[M1_STANDBY_SEL]); // R22
    end else if (data_ph_w && !(int_q && suppress_w)) begin // R12
      rd_n_d = we_q;
      if (we_q) begin
        if (byte_s) wl_n_d = 1'b0; // R11
        else begin
          wl_n_d = !be_q[0]; // R10
          wh_n_d = !be_q[1]; // R10
        end
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      read_strobe_n_o <= 1'b1;
      write_strobe_low_byte_n_o <= 1'b1;
      write_strobe_high_byte_n_o <= 1'b1;
      strobe_oe_n_o <= 1'b1;
      ale_o <= 1'b0;
      bus_release_ack_n_o <= 1'b1;
      port3_ctrl_o <= 1'b0;
      internal_clk_run_o <= 1'b1;
    end else begin
      read_strobe_n_o <= rd_n_d; // R22
      write_strobe_low_byte_n_o <= wl_n_d;
      write_strobe_high_byte_n_o <= wh_n_d;
      strobe_oe_n_o <= float_q; // R15 R16
      ale_o <= expand_w && addr_ph_w; // R13 R25
      bus_release_ack_n_o <= !(state_q == ST_HOLD); // R14
      port3_ctrl_o <= expand_w; // R9
      internal_clk_run_o <= !stall_w; // R17
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      p1_o <= 8'h00;
      p2_o <= 8'h00;
      p1_oe_n_o <= 1'b1;
      p2_oe_n_o <= 1'b1;
      addr_hi_o <= 2'h0;
      area_select_n_o <= CS_NONE;
      ready_sample_strobe_n_o <= 1'b1;
      p0_oe_n_o <= 1'b1;
    end else begin
      p0_oe_n_o <= !expand_w || float_q; // R23 R15
      addr_hi_o <= addr_q[17:16]; // R23
      area_select_n_o <= (addr_ph_w || data_ph_w) ? area_decode(addr_q, int_q) : CS_NONE; // R1
      ready_sample_strobe_n_o <= !(data_ph_w && ext_w); // R2
      if (byte_s || !data_ph_w) begin
        p1_o <= addr_q[15:8]; // R4 R5
        p1_oe_n_o <= !expand_w || float_q; // R5
      end else begin
        p1_o <= wdata_q[15:8]; // R4
        p1_oe_n_o <= !expand_w || float_q || !we_q;
      end
      if (!data_ph_w) begin
        p2_o <= addr_q[7:0]; // R6 R7
        p2_oe_n_o <= !expand_w || float_q;
      end else begin
        p2_o <= (byte_s && be_q[1] && !be_q[0]) ? wdata_q[15:8] : wdata_q[7:0]; // R7 R6
        p2_oe_n_o <= !expand_w || float_q || !we_q;
      end
    end
  end

  // port4 bit2: follows the sampled bus clock, not the ready-stopped internal clock
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bus_clk_o <= 1'b0;
    end else if (mode_w == MODE_MICRO) begin
      bus_clk_o <= suppress_w ? mode1_q[M1_P42_LATCH] : bclk_s; // R20 R21
    end else begin
      bus_clk_o <= mode0_q[M0_CLKOUT] ? bclk_s : mode1_q[M1_P42_LATCH]; // R18
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_re_i) begin
      unique case (reg_addr_i)
        REG_MODE0: reg_rdata_o <= mode0_q;
        REG_MODE1: reg_rdata_o <= mode1_q;
        REG_STATUS: reg_rdata_o <= {3'h0, float_q, state_q == ST_HOLD, state_q};
        default: reg_rdata_o <= 8'h00;
      endcase
    end
  end

  a_area_bank3: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R1
    (state_q == ST_DATA && !int_q && addr_q[23:16] >= 8'h08 && addr_q[23:16] <= 8'h0b)
    |=> area_select_n_o == 5'h17) else $error("area select 3 missing");
  a_ready_freeze: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R17
    (state_q == ST_DATA && !ready_n_s) |=> $stable(cnt_q) && state_q == ST_DATA)
    else $error("internal clock advanced during ready low");
  a_byte_high_idle: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R11
    byte_s |=> write_strobe_high_byte_n_o) else $error("high write strobe in 8-bit mode");
  a_suppress_int: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R12
    (expand_w && !standby_w && data_ph_w && int_q && suppress_w)
    |=> read_strobe_n_o && write_strobe_low_byte_n_o && write_strobe_high_byte_n_o)
    else $error("strobe on suppressed internal access");
  a_hold_float: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R15
    $fell(bus_release_ack_n_o) |-> !strobe_oe_n_o ##[1:14] strobe_oe_n_o)
    else $error("bus not floated after hold ack");
  a_hold_release: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R16
    $rose(bus_release_ack_n_o) |-> strobe_oe_n_o ##[1:14] !strobe_oe_n_o)
    else $error("bus not driven after hold release");
  a_ale_addr: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R25
    ale_o |-> read_strobe_n_o && write_strobe_low_byte_n_o && !p2_oe_n_o == !float_q)
    else $error("latch strobe overlaps data term");
  a_upper_addr: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R5
    (byte_s && expand_w && !float_q) |=> !p1_oe_n_o && p1_o == $past(addr_q[15:8]))
    else $error("upper port not address in 8-bit mode");
  a_boot_micro: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R19
    (!boot_done_q && boot_pipe_q[1] && boot_s) |=> mode_w == MODE_MICRO)
    else $error("boot strap ignored");
  a_clk_micro: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R20
    (mode_w == MODE_MICRO && !suppress_w) |=> bus_clk_o == $past(bclk_s))
    else $error("bus clock not output in microprocessor mode");
  a_ack_hold: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R14
    (state_q == ST_IDLE && expand_w && !hold_n_s && fall_w) |=> ##1 !bus_release_ack_n_o)
    else $error("hold request not acknowledged");
endmodule

/* shared/ext_bus_pkg.sv */
// constants shared by the external memory bus interface
// assumes a 50 MHz system clock and a sampled bus clock
package ext_bus_pkg;
  localparam logic [1:0] MODE_SINGLE = 2'h0;
  localparam logic [1:0] MODE_EXPAND = 2'h1;
  localparam logic [1:0] MODE_MICRO = 2'h2;
  // register indices on the plain register port
  localparam logic [1:0] REG_MODE0 = 2'h0;
  localparam logic [1:0] REG_MODE1 = 2'h1;
  localparam logic [1:0] REG_STATUS = 2'h2;
  // mode0 fields
  localparam int M0_MODE_LSB = 0;
  localparam int M0_WAIT = 2;
  localparam int M0_CLKOUT = 7;
  // mode1 fields
  localparam int M1_WAIT_SEL = 0;
  localparam int M1_SUPPRESS = 1;
  localparam int M1_STANDBY_SEL = 2;
  localparam int M1_P42_LATCH = 3;
  localparam int M1_P42_DIR = 4;
  localparam logic [7:0] MODE0_RST = 8'h00;
  localparam logic [7:0] MODE1_RST = 8'h00;
  // bus timing in half bus clock cycles (one count per bus clock edge)
  localparam logic [2:0] ADDR_HALVES = 3'h2;
  localparam logic [2:0] DATA_HALVES_NOWAIT = 3'h2;
  localparam logic [2:0] DATA_HALVES_WAIT15 = 3'h4;
  localparam logic [2:0] DATA_HALVES_WAIT2 = 3'h6;
  localparam logic [2:0] HOLD_FLOAT_HALVES = 3'h2;
  // bank limits of the area selects
  localparam logic [7:0] BANK_CS1_LAST = 8'h03;
  localparam logic [7:0] BANK_CS2_LAST = 8'h07;
  localparam logic [7:0] BANK_CS3_LAST = 8'h0b;
  localparam logic [7:0] BANK_CS4_LAST = 8'h0f;
  localparam logic [4:0] CS_NONE = 5'h1f;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_DATA = 3'b010,
    ST_HOLD = 3'b011,
    ST_UNHOLD = 3'b100
  } bus_state_e;
endpackage

/* testbench/ext_mem_model.sv */
// external memory model on the multiplexed bus: address latch and 16 byte pairs
// assumes pin outputs of the bus block and its sys clock for sampling strobes
`timescale 1ns/1ps
module ext_mem_model (
  input wire logic clk_i, // sys clock
  input wire logic byte_i, // high: 8-bit bus
  input wire logic stretch_i, // feed ready from the sample strobe
  input wire logic ale_i, // address latch strobe
  input wire logic [7:0] p1_i, // upper port from block
  input wire logic [7:0] p2_i, // lower port from block
  input wire logic rd_n_i, // read strobe
  input wire logic wl_n_i, // low write strobe
  input wire logic wh_n_i, // high write strobe
  input wire logic ready_sample_strobe_n_i, // ready sample strobe
  input wire logic cs3_n_i, // area select 3
  output logic [7:0] p1_o, // upper port to block
  output logic [7:0] p2_o, // lower port to block
  output logic ready_n_o // ready to block
);
  logic [15:0] lat;
  logic [7:0] mem_e [16];
  logic [7:0] mem_o [16];
  logic [3:0] cnt;
  logic odd;
  assign odd = byte_i && lat[0];
  initial begin
    p1_o = 8'h00;
    p2_o = 8'h00;
    cnt = 4'h0;
  end
  // sampled on the sys clock, since the strobe falls in the step the port turns to data
  always @(posedge clk_i) begin
    if (ale_i) lat <= {p1_i, p2_i};
    if (!wl_n_i && !odd) mem_e[lat[4:1]] <= p2_i;
    if (!wl_n_i && odd) mem_o[lat[4:1]] <= p2_i;
    if (!wh_n_i && !byte_i) mem_o[lat[4:1]] <= p1_i;
    // a released bus toggles every cycle so a stale value never passes for data
    if (!rd_n_i) begin
      p2_o <= odd ? mem_o[lat[4:1]] : mem_e[lat[4:1]];
      p1_o <= mem_o[lat[4:1]];
    end else begin
      p2_o <= ~p2_o;
      p1_o <= ~p1_o;
    end
    cnt <= ready_sample_strobe_n_i ? 4'h0 : (cnt == 4'hf ? cnt : cnt + 4'h1);
  end
  // ready low for one bus clock (8 sys clocks) of each selected sample term
  assign ready_n_o = !(stretch_i && !ready_sample_strobe_n_i && !cs3_n_i && cnt < 4'h8);
endmodule

/* testbench/external_memory_bus_interface_test.sv */
// self-checking bench for the external memory bus interface
// assumes the memory model on the far side and a free bus clock of 160 ns
`timescale 1ns/1ps
module external_memory_bus_interface_test
  import ext_bus_pkg::*;
;
  logic sys_clk_i = 0, resetn_i = 0, bus_clk_i = 0, boot_mode_pin_i = 0, byte_width_i = 0;
  logic hold_req_n_i = 1, wait_instruction_i = 0, stop_instruction_i = 0, stretch = 0;
  logic [1:0] reg_addr_i = 2'h0, req_be_i = 2'h0;
  logic [7:0] reg_wdata_i = 8'h00, reg_rdata_o, p1_i, p1_o, p2_i, p2_o;
  logic reg_we_i = 0, reg_re_i = 0, req_i = 0, req_we_i = 0, req_internal_i = 0;
  logic [23:0] req_addr_i = 24'h000000;
  logic [15:0] req_wdata_i = 16'h0000, int_rdata_i = 16'h0000, rdata_o;
  logic busy_o, done_o, p1_oe_n_o, p2_oe_n_o, ready_sample_strobe_n_o, p0_oe_n_o;
  logic read_strobe_n_o, write_strobe_low_byte_n_o, write_strobe_high_byte_n_o;
  logic strobe_oe_n_o, ale_o, bus_release_ack_n_o, port3_ctrl_o, internal_clk_run_o;
  logic bus_clk_o, ready_n_i;
  logic [1:0] addr_hi_o;
  logic [4:0] area_select_n_o;
  logic [5:0] seen;
  int n_mismatch = 0, samples_checked = 0, t0, t15, t2, tr;
  always #10 sys_clk_i = ~sys_clk_i;
  always #80 bus_clk_i = ~bus_clk_i;
  ext_bus_if ext_bus_if_i (.sys_clk_i, .resetn_i, .bus_clk_i, .boot_mode_pin_i,
    .byte_width_i, .hold_req_n_i, .ready_n_i, .wait_instruction_i, .stop_instruction_i,
    .reg_addr_i, .reg_wdata_i, .reg_we_i, .reg_re_i, .reg_rdata_o, .req_i, .req_addr_i,
    .req_we_i, .req_be_i, .req_internal_i, .req_wdata_i, .int_rdata_i, .busy_o, .done_o,
    .rdata_o, .p1_i, .p1_o, .p1_oe_n_o, .p2_i, .p2_o, .p2_oe_n_o, .addr_hi_o,
    .area_select_n_o, .ready_sample_strobe_n_o, .p0_oe_n_o, .read_strobe_n_o,
    .write_strobe_low_byte_n_o, .write_strobe_high_byte_n_o, .strobe_oe_n_o, .ale_o,
    .bus_release_ack_n_o, .port3_ctrl_o, .internal_clk_run_o, .bus_clk_o);
  ext_mem_model ext_mem_model_i (.clk_i(sys_clk_i), .byte_i(byte_width_i),
    .stretch_i(stretch), .ale_i(ale_o), .p1_i(p1_o), .p2_i(p2_o),
    .rd_n_i(read_strobe_n_o), .wl_n_i(write_strobe_low_byte_n_o),
    .wh_n_i(write_strobe_high_byte_n_o), .ready_sample_strobe_n_i(ready_sample_strobe_n_o),
    .cs3_n_i(area_select_n_o[3]), .p1_o(p1_i), .p2_o(p2_i), .ready_n_o(ready_n_i));
  // sticky flags: 0 low write, 1 high write, 2 read, 3 clock stopped,
  // 4 upper port off its address in a write term, 5 only select 3 low
  always @(posedge sys_clk_i) begin
    seen <= seen | {area_select_n_o === 5'h17,
      !write_strobe_low_byte_n_o && (p1_oe_n_o || p1_o !== req_addr_i[15:8]),
      internal_clk_run_o === 1'b0, read_strobe_n_o === 1'b0,
      write_strobe_high_byte_n_o === 1'b0, write_strobe_low_byte_n_o === 1'b0};
  end
  task automatic check_vec(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic check_gt(input int a, input int b);
    samples_checked++;
    if (a <= b) begin
      n_mismatch++;
      $display("Error at %0t: span %0d not above %0d", $time, a, b);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic reg_wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_we_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_we_i <= 1'b0;
  endtask
  task automatic reg_chk(input logic [1:0] a, input logic [7:0] exp);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_re_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_re_i <= 1'b0;
    @(posedge sys_clk_i);
    check_vec(reg_rdata_o, exp);
  endtask
  // one access; returns cycles from request to the done pulse
  task automatic access(input logic [23:0] a, input logic w, input logic [1:0] be,
      input logic intl, input logic [15:0] d, output int cyc);
    @(negedge sys_clk_i);
    seen = '0;
    @(posedge sys_clk_i);
    req_i <= 1'b1;
    req_addr_i <= a;
    req_we_i <= w;
    req_be_i <= be;
    req_internal_i <= intl;
    req_wdata_i <= d;
    @(posedge sys_clk_i);
    req_i <= 1'b0;
    cyc = 0;
    while (done_o !== 1'b1 && cyc < 400) begin
      @(posedge sys_clk_i);
      cyc++;
    end
    check_gt(400, cyc);
  endtask
  task automatic t_reset();
    reg_chk(REG_MODE0, MODE0_RST);
    reg_chk(REG_MODE1, MODE1_RST);
    reg_chk(2'h3, 8'h00);
    check_vec(port3_ctrl_o, 1'b0);
    reg_wr(REG_MODE0, 8'h05);
    reg_chk(REG_MODE0, 8'h05);
    check_vec(port3_ctrl_o, 1'b1);
  endtask
  task automatic t_word();
    access(24'h080010, 1'b1, 2'h3, 1'b0, 16'ha55a, t0);
    check_vec(seen[5:0] & 6'h23, 6'h23);
    access(24'h0a0014, 1'b1, 2'h1, 1'b0, 16'h0077, t0);
    check_vec(seen[1:0], 2'h1);
    check_vec({addr_hi_o, p0_oe_n_o}, 3'h4);
    access(24'h080010, 1'b0, 2'h3, 1'b0, 16'h0000, t0);
    check_vec(rdata_o, 16'ha55a);
    check_vec(seen[2], 1'b1);
  endtask
  task automatic t_byte();
    @(posedge sys_clk_i);
    byte_width_i <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    access(24'h080013, 1'b1, 2'h2, 1'b0, 16'hc300, t0);
    check_vec(seen[1:0], 2'h1);
    check_vec(seen[4], 1'b0);
    access(24'h080013, 1'b0, 2'h2, 1'b0, 16'h0000, t0);
    check_vec(rdata_o, 16'hc3c3);
    @(posedge sys_clk_i);
    byte_width_i <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
  endtask
  task automatic t_wait();
    access(24'h080020, 1'b1, 2'h3, 1'b0, 16'h1111, t0);
    reg_wr(REG_MODE0, 8'h01);
    reg_wr(REG_MODE1, 8'h01);
    access(24'h080020, 1'b1, 2'h3, 1'b0, 16'h2222, t15);
    check_gt(t15, t0 + 4);
    reg_wr(REG_MODE1, 8'h00);
    access(24'h080020, 1'b1, 2'h3, 1'b0, 16'h3333, t2);
    check_gt(t2, t15 + 4);
    stretch <= 1'b1;
    access(24'h080020, 1'b1, 2'h3, 1'b0, 16'h4444, tr);
    check_gt(tr, t2 + 4);
    check_vec(seen[3], 1'b1);
    reg_wr(REG_MODE0, 8'h05);
    access(24'h080020, 1'b1, 2'h3, 1'b0, 16'h5555, tr);
    check_gt(tr, t0 + 4);
    stretch <= 1'b0;
  endtask
  task automatic t_internal();
    int n;
    reg_wr(REG_MODE1, 8'h02);
    @(posedge sys_clk_i);
    int_rdata_i <= 16'h1234;
    access(24'h000100, 1'b0, 2'h3, 1'b1, 16'h0000, n);
    check_vec(rdata_o, 16'h1234);
    check_vec(seen[2:0], 3'h0);
    reg_wr(REG_MODE1, 8'h00);
  endtask
  task automatic t_clk_out(input logic [7:0] m0, input logic exp_run);
    int n;
    logic prev;
    reg_wr(REG_MODE0, m0);
    repeat (4) @(posedge sys_clk_i);
    n = 0;
    prev = bus_clk_o;
    repeat (40) begin
      @(posedge sys_clk_i);
      if (bus_clk_o !== prev) n++;
      prev = bus_clk_o;
    end
    check_vec(n > 2, exp_run);
  endtask
  task automatic t_hold();
    int n;
    @(posedge sys_clk_i);
    hold_req_n_i <= 1'b0;
    n = 0;
    while (bus_release_ack_n_o !== 1'b0 && n < 100) begin
      @(posedge sys_clk_i);
      n++;
    end
    check_gt(100, n);
    check_vec({busy_o, p2_oe_n_o}, 2'h2);
    for (n = 0; p2_oe_n_o !== 1'b1 && n < 100; n++) @(posedge sys_clk_i);
    check_gt(n, 4);
    check_vec({p1_oe_n_o, strobe_oe_n_o}, 2'h3);
    @(posedge sys_clk_i);
    hold_req_n_i <= 1'b1;
    for (n = 0; bus_release_ack_n_o !== 1'b1 && n < 100; n++) @(posedge sys_clk_i);
    check_vec(p2_oe_n_o, 1'b1);
    for (n = 0; p2_oe_n_o !== 1'b0 && n < 100; n++) @(posedge sys_clk_i);
    check_gt(n, 4);
    check_gt(100, n);
  endtask
  task automatic t_boot();
    @(posedge sys_clk_i);
    resetn_i <= 1'b0;
    boot_mode_pin_i <= 1'b1;
    repeat (5) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    reg_chk(REG_MODE0, {6'h00, MODE_MICRO});
    check_vec(port3_ctrl_o, 1'b1);
  endtask
  initial begin
    #300000;
    n_mismatch++;
    conclude();
  end
  initial begin
    repeat (5) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    t_reset();
    t_word();
    t_byte();
    t_wait();
    t_internal();
    t_clk_out(8'h05, 1'b0);
    t_clk_out(8'h85, 1'b1);
    t_clk_out(8'h06, 1'b1);
    reg_wr(REG_MODE1, 8'h1a);
    t_clk_out(8'h06, 1'b0);
    t_hold();
    t_boot();
    conclude();
  end
endmodule
